/* File: design/nisp_map.svh */
// register offsets, field positions and reset values of the interrupt state block
`ifndef NISP_MAP_SVH
`define NISP_MAP_SVH

`define NISP_NIRQ        35
`define NISP_NUM_W       6
`define NISP_ADDR_W      12
`define NISP_PRIO_W      4
`define NISP_PRIO_LSB    4
`define NISP_NPRIO_REG   9

`define NISP_OFF_SET_EN  12'h100
`define NISP_OFF_CLR_EN  12'h180
`define NISP_OFF_SET_PND 12'h200
`define NISP_OFF_CLR_PND 12'h280
`define NISP_OFF_ACTIVE  12'h300
`define NISP_OFF_LEVEL   12'h380
`define NISP_OFF_PRIO    12'h400
`define NISP_OFF_SYSCTL  12'hD10
`define NISP_OFF_TRIGGER 12'hF00

`define NISP_SYSCTL_UPP_BIT  1
`define NISP_TRIG_ID_MSB     8
`define NISP_PRIO_RESET      4'h0
`define NISP_VEC_RESET       35'h0
`define NISP_RDATA_UNMAPPED  32'h0000_0000

`endif

/* File: design/nisp_pkg.sv */
// types shared by the interrupt state block and its users
`include "nisp_map.svh"
package nisp_pkg;

    typedef logic [`NISP_NIRQ-1:0]   nisp_vec_t;
    typedef logic [`NISP_PRIO_W-1:0] nisp_prio_t;
    typedef logic [`NISP_NUM_W-1:0]  nisp_num_t;

    typedef struct packed {
        logic [`NISP_ADDR_W-1:0] addr;
        logic [31:0]             wdata;
        logic [3:0]              be;
        logic                    wr;
        logic                    rd;
        logic                    priv;
    } nisp_bus_t;

    typedef struct packed {
        logic      enter;
        nisp_num_t enter_num;
        logic      ret;
        nisp_num_t ret_num;
    } nisp_core_t;

    typedef struct packed {
        logic       req;
        nisp_num_t  num;
        nisp_prio_t prio;
    } nisp_sel_t;

    typedef struct packed {
        nisp_vec_t                        sync1;
        nisp_vec_t                        sync2;
        nisp_vec_t                        prev;
        nisp_vec_t                        pend;
        nisp_vec_t                        act;
        nisp_vec_t                        en;
        nisp_vec_t                        level;
        nisp_prio_t [`NISP_NIRQ-1:0]      prio;
        logic                             upp;
        logic [31:0]                      rdata;
        nisp_sel_t                        sel;
    } nisp_state_t;

endpackage : nisp_pkg

/* File: design/nisp_irq_state.sv */
// interrupt pending/active tracking, priorities and software trigger
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "nisp_map.svh"
module nisp_irq_state (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire nisp_pkg::nisp_bus_t  i_bus,
    output logic [31:0]            o_rdata,
    input  wire nisp_pkg::nisp_vec_t  i_irq_line,
    input  wire nisp_pkg::nisp_core_t i_core,
    output nisp_pkg::nisp_sel_t    o_sel,
    output nisp_pkg::nisp_vec_t    o_active
);
    import nisp_pkg::*;

    nisp_state_t s;
    nisp_state_t next_s;

    nisp_vec_t   rise;
    nisp_vec_t   wmask;
    nisp_vec_t   trig_vec;
    logic [63:0] rd_vec;
    logic        word_hi;
    logic        trig_ok;
    logic [8:0]  trig_id;
    logic [3:0]  prio_idx;
    logic        prio_hit;
    logic        best_found;
    nisp_prio_t  best_prio;
    nisp_num_t   best_num;

    always_comb begin
        next_s     = s;
        rise       = s.sync2 & ~s.prev;
        word_hi    = i_bus.addr[2];
        wmask      = word_hi ? nisp_vec_t'({i_bus.wdata, 32'h0} >> 32) << 32
                             : nisp_vec_t'(i_bus.wdata);
        trig_id    = i_bus.wdata[`NISP_TRIG_ID_MSB:0];
        trig_ok    = i_bus.wr && i_bus.addr == `NISP_OFF_TRIGGER
                     && (i_bus.priv || s.upp);
        trig_vec   = '0;
        prio_idx   = i_bus.addr[5:2];
        prio_hit   = i_bus.addr[11:6] == `NISP_OFF_PRIO >> 6
                     && i_bus.addr[1:0] == 2'h0 && prio_idx < 4'(`NISP_NPRIO_REG);
        rd_vec     = '0;
        best_found = 1'b0;
        best_prio  = '1;
        best_num   = '0;

        // two-flop sync, then edge reference
        next_s.sync1 = i_irq_line;
        next_s.sync2 = s.sync1;
        next_s.prev  = s.sync2;

        // ids beyond the implemented range are dropped
        if (trig_ok && trig_id < 9'(`NISP_NIRQ)) begin
            trig_vec[trig_id[`NISP_NUM_W-1:0]] = 1'b1;
        end

        // active flags: return first, then entry so re-entry of the same line sticks
        if (i_core.ret && i_core.ret_num < `NISP_NUM_W'(`NISP_NIRQ)) begin
            next_s.act[i_core.ret_num] = 1'b0;
            if (s.level[i_core.ret_num] && s.sync2[i_core.ret_num]) begin
                next_s.pend[i_core.ret_num] = 1'b1;
            end
        end
        if (i_core.enter && i_core.enter_num < `NISP_NUM_W'(`NISP_NIRQ)) begin
            next_s.act[i_core.enter_num]  = 1'b1;
            next_s.pend[i_core.enter_num] = 1'b0;
        end

        // clearing goes before every set so a same-cycle event survives
        if (i_bus.wr && i_bus.addr[11:3] == `NISP_OFF_CLR_PND >> 3 && !i_bus.addr[1]) begin
            // level lines still high stay pending; active is never touched
            next_s.pend = next_s.pend & ~(wmask & ~(s.level & s.sync2));
        end
        if (i_bus.wr && i_bus.addr[11:3] == `NISP_OFF_SET_PND >> 3 && !i_bus.addr[1]) begin
            next_s.pend = next_s.pend | wmask;
        end
        next_s.pend = next_s.pend | trig_vec;
        // enable plays no part here, so disabled lines pend too
        next_s.pend = next_s.pend | rise;
        next_s.pend = next_s.pend | (s.sync2 & ~next_s.act);

        if (i_bus.wr && i_bus.addr[11:3] == `NISP_OFF_SET_EN >> 3 && !i_bus.addr[1]) begin
            next_s.en = s.en | wmask;
        end
        if (i_bus.wr && i_bus.addr[11:3] == `NISP_OFF_CLR_EN >> 3 && !i_bus.addr[1]) begin
            next_s.en = s.en & ~wmask;
        end
        if (i_bus.wr && i_bus.addr[11:3] == `NISP_OFF_LEVEL >> 3 && !i_bus.addr[1]) begin
            next_s.level = (s.level & ~(word_hi ? ~(nisp_vec_t'(32'hFFFF_FFFF)) :
                                                   nisp_vec_t'(32'hFFFF_FFFF))) | wmask;
        end
        if (i_bus.wr && i_bus.addr == `NISP_OFF_SYSCTL && i_bus.priv) begin
            next_s.upp = i_bus.wdata[`NISP_SYSCTL_UPP_BIT];
        end

        // byte lanes write single priority fields
        for (int n = 0; n < `NISP_NIRQ; n++) begin
            if (i_bus.wr && prio_hit && prio_idx == 4'(n / 4) && i_bus.be[n % 4]) begin
                next_s.prio[n] = i_bus.wdata[(n % 4) * 8 + `NISP_PRIO_LSB +: `NISP_PRIO_W];
            end
        end

        // read data in the cycle after the strobe, zero otherwise
        next_s.rdata = `NISP_RDATA_UNMAPPED;
        if (i_bus.rd) begin
            case (i_bus.addr & 12'hFF8)
                `NISP_OFF_SET_EN, `NISP_OFF_CLR_EN: rd_vec = 64'(s.en);
                `NISP_OFF_SET_PND, `NISP_OFF_CLR_PND: rd_vec = 64'(s.pend);
                `NISP_OFF_ACTIVE: rd_vec = 64'(s.act);
                `NISP_OFF_LEVEL: rd_vec = 64'(s.level);
                default: rd_vec = '0;
            endcase
            if (i_bus.addr[1:0] == 2'h0) begin
                next_s.rdata = word_hi ? rd_vec[63:32] : rd_vec[31:0];
            end
            if (i_bus.addr == `NISP_OFF_SYSCTL) begin
                next_s.rdata = 32'(s.upp) << `NISP_SYSCTL_UPP_BIT;
            end
            if (prio_hit) begin
                next_s.rdata = '0;
                for (int n = 0; n < `NISP_NIRQ; n++) begin
                    if (prio_idx == 4'(n / 4)) begin
                        next_s.rdata[(n % 4) * 8 + `NISP_PRIO_LSB +: `NISP_PRIO_W] = s.prio[n];
                    end
                end
            end
        end

        // strict less keeps the lower number on equal priority
        for (int n = 0; n < `NISP_NIRQ; n++) begin
            if (s.pend[n] && s.en[n] && (!best_found || s.prio[n] < best_prio)) begin
                best_found = 1'b1;
                best_prio  = s.prio[n];
                best_num   = `NISP_NUM_W'(n);
            end
        end
        next_s.sel.req  = best_found;
        next_s.sel.num  = best_num;
        next_s.sel.prio = best_found ? best_prio : `NISP_PRIO_RESET;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_rdata  = s.rdata;
    assign o_sel    = s.sel;
    assign o_active = s.act;

endmodule : nisp_irq_state

/* File: sim/nisp_irq_state_props.sv */
// port checker for the interrupt state block
`timescale 1ns/100ps
module nisp_irq_state_props (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire nisp_pkg::nisp_bus_t  i_bus,
    input  wire logic [31:0]          o_rdata,
    input  wire nisp_pkg::nisp_vec_t  i_irq_line,
    input  wire nisp_pkg::nisp_core_t i_core,
    input  wire nisp_pkg::nisp_sel_t  o_sel,
    input  wire nisp_pkg::nisp_vec_t  o_active
);
    import nisp_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    chk_rd_data_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside a read");
    chk_enter_sets_active: assert property (i_core.enter |=> o_active[$past(i_core.enter_num)])
        else $error("entry did not set active");
    chk_ret_clears_active: assert property (i_core.ret && !i_core.enter |=> !o_active[$past(i_core.ret_num)])
        else $error("return did not clear active");
    chk_idle_prio_zero: assert property (!o_sel.req |-> o_sel.prio == 4'h0)
        else $error("priority shown without request");
    chk_prio_low_zero: assert property ($past(i_bus.rd) && $past(i_bus.addr[11:8]) == 4'h4 |-> (o_rdata & 32'h0F0F_0F0F) == 32'h0)
        else $error("priority low nibble not zero");
    chk_active_word: assert property ($past(i_bus.rd) && $past(i_bus.addr) == 12'h300 |-> o_rdata == $past(o_active[31:0]))
        else $error("active word differs from flags");
    chk_sel_num_range: assert property (o_sel.req |-> o_sel.num < 6'd35)
        else $error("selected number out of range");
    chk_active_holds: assert property (!$past(i_core.enter) && !$past(i_core.ret) |-> $stable(o_active))
        else $error("active flags moved without core event");
endmodule : nisp_irq_state_props

bind nisp_irq_state nisp_irq_state_props nisp_irq_state_props_i (.i_clk, .i_rst_b, .i_bus,
    .o_rdata, .i_irq_line, .i_core, .o_sel, .o_active);

/* File: sim/nisp_far_model.sv */
// core model: enters the offered interrupt on command, returns on command
`timescale 1ns/100ps
module nisp_far_model (
    input  wire logic                i_clk,
    input  wire logic                i_go,
    input  wire logic                i_back,
    input  wire nisp_pkg::nisp_sel_t i_sel,
    output nisp_pkg::nisp_core_t     o_core = '0
);
    import nisp_pkg::*;
    nisp_num_t cur = '0;
    // only what is offered is entered, never a disabled line
    always @(posedge i_clk) begin
        o_core.enter     <= i_go & i_sel.req;
        o_core.enter_num <= i_sel.num;
        o_core.ret       <= i_back;
        o_core.ret_num   <= cur;
        if (i_go & i_sel.req)
            cur <= i_sel.num;
    end
endmodule : nisp_far_model

/* File: sim/nisp_irq_state_tb_top.sv */
// self-checking bench for the interrupt state block
`timescale 1ns/100ps
module nisp_irq_state_tb_top;
    import nisp_pkg::*;
    logic        i_clk = 0;
    logic        i_rst_b = 0;
    nisp_bus_t   bus_q = '0;
    nisp_vec_t   line_q = '0;
    logic        go = 0;
    logic        back = 0;
    logic [31:0] rdata;
    nisp_core_t  core;
    nisp_sel_t   sel;
    nisp_vec_t   act;
    int          n_errors = 0;
    int          check_count = 0;
    nisp_irq_state nisp_irq_state_i (.i_clk, .i_rst_b, .i_bus(bus_q), .o_rdata(rdata),
        .i_irq_line(line_q), .i_core(core), .o_sel(sel), .o_active(act));
    nisp_far_model nisp_far_model_i (.i_clk, .i_go(go), .i_back(back), .i_sel(sel),
        .o_core(core));
    initial forever #20 i_clk = ~i_clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b,
                      input logic p);
        bus_q <= '{a, d, b, 1'b1, 1'b0, p};
        @(posedge i_clk);
        bus_q <= '0;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus_q <= '{a, 32'h0, 4'hF, 1'b0, 1'b1, 1'b1};
        @(posedge i_clk);
        bus_q <= '0;
        #1 chk("rdata", e, rdata);
        @(posedge i_clk);
    endtask : rd
    // one core pulse: entry if g, else return
    task automatic step(input logic g);
        go <= g;
        back <= !g;
        @(posedge i_clk);
        go <= 1'b0;
        back <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask : step
    task automatic prio_case;
        rd(12'h404, 32'h0);
        rd(12'h7F0, 32'h0);
        wr(12'h408, 32'hFFFF_FFFF, 4'hF, 1'b1);
        rd(12'h408, 32'hF0F0_F0F0);
        wr(12'h400, 32'h0000_A5C3, 4'h2, 1'b1);
        rd(12'h400, 32'h0000_A000);
    endtask : prio_case
    task automatic sel_case;
        wr(12'h100, 32'h0000_0006, 4'hF, 1'b1);
        wr(12'h200, 32'h0000_0006, 4'hF, 1'b1);
        #1 chk("sel", 32'h0000_0420, 32'(sel));
        @(posedge i_clk);
        step(1'b1);
        chk("active", 32'h0000_0004, 32'(act));
        rd(12'h300, 32'h0000_0004);
        rd(12'h200, 32'h0000_0002);
        wr(12'h280, 32'h0000_0006, 4'hF, 1'b1);
        rd(12'h300, 32'h0000_0004);
        step(1'b0);
        rd(12'h300, 32'h0);
    endtask : sel_case
    task automatic trig_case;
        wr(12'hF00, 32'h0000_0003, 4'hF, 1'b0);
        wr(12'hD10, 32'h0000_0002, 4'hF, 1'b0);
        wr(12'hF00, 32'h0000_0003, 4'hF, 1'b0);
        rd(12'h200, 32'h0);
        wr(12'hD10, 32'h0000_0002, 4'hF, 1'b1);
        wr(12'hF00, 32'h0000_0003, 4'hF, 1'b0);
        rd(12'h200, 32'h0000_0008);
    endtask : trig_case
    task automatic line_case;
        wr(12'h380, 32'h0000_0010, 4'hF, 1'b1);
        line_q <= 35'h10;
        repeat (4) @(posedge i_clk);
        rd(12'h200, 32'h0000_0018);
        wr(12'h100, 32'h0000_0010, 4'hF, 1'b1);
        step(1'b1);
        step(1'b0);
        rd(12'h200, 32'h0000_0018);
        wr(12'h280, 32'h0000_0010, 4'hF, 1'b1);
        rd(12'h200, 32'h0000_0018);
        line_q <= '0;
        repeat (4) @(posedge i_clk);
        wr(12'h280, 32'h0000_0010, 4'hF, 1'b1);
        rd(12'h200, 32'h0000_0008);
    endtask : line_case
    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        prio_case();
        sel_case();
        trig_case();
        line_case();
        report_and_stop();
    end
    // guard against a hung run
    initial begin
        repeat (5000) @(posedge i_clk);
        n_errors++;
        report_and_stop();
    end
endmodule : nisp_irq_state_tb_top
